/* File: core/gpio_port.sv */
// Eight-pin GPIO port with external interrupt vectors
`timescale 1ns/1ps
`include "gpio_params.svh"
module gpio_port #(
  parameter logic [7:0] IRQ_CAPABLE = 8'h7E,
  parameter logic [7:0] VEC_PIN0 = 8'h06,
  parameter logic [7:0] VEC_PIN1 = 8'h18,
  parameter logic [7:0] VEC_PIN2 = 8'h60,
  parameter logic [7:0] VEC_PIN3 = 8'h00
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire gpio_pkg::reg_req_type req,
  output logic [7:0] rdata,
  input wire logic [7:0] pin_in,
  output gpio_pkg::pad_ctl_type pad,
  input wire logic [7:0] alt_out_en,
  input wire logic [7:0] alt_out_val,
  input wire logic [7:0] alt_in_en,
  output logic [7:0] alt_in,
  input wire logic [7:0] adc_sel,
  output logic [7:0] adc_sw,
  input wire logic irq_mask,
  input wire logic [3:0] vec_fetch,
  output logic [3:0] irq_req
);
  localparam int NV = `GPIO_NUM_VEC;
  localparam logic [7:0] VEC_PINS [NV] = '{VEC_PIN0, VEC_PIN1, VEC_PIN2, VEC_PIN3};

  logic [7:0] port_data_latch_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] port_option_reg;
  logic [7:0] ext_irq_sensitivity_ctl_reg;
  logic [7:0] ext_irq_select_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] drive_lvl;
  logic [7:0] drive_en;
  logic [7:0] int_en;
  logic [7:0] rd_next;
  logic [NV-1:0] pending;
  logic [NV-1:0] sens_clear;

  // Register write decode, one address per register
  function automatic logic hit(input gpio_pkg::reg_req_type r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Two-stage synchroniser on every pin input
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Data latch; an input pin keeps its state, only the stored value moves
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_data_latch_reg <= `GPIO_RST_DATA;
    end else if (hit(req, `GPIO_ADDR_DATA)) begin
      port_data_latch_reg <= req.wdata;
    end
  end

  // Direction register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_direction_reg <= `GPIO_RST_DIR;
    end else if (hit(req, `GPIO_ADDR_DIR)) begin
      port_direction_reg <= req.wdata;
    end
  end

  // Option register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_option_reg <= `GPIO_RST_OPT;
    end else if (hit(req, `GPIO_ADDR_OPT)) begin
      port_option_reg <= req.wdata;
    end
  end

  // Sensitivity and select registers; two sensitivity bits per vector, bit 0 used
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq_sensitivity_ctl_reg <= `GPIO_RST_SENS;
      ext_irq_select_reg <= `GPIO_RST_SEL;
    end else begin
      if (hit(req, `GPIO_ADDR_SENS)) begin
        ext_irq_sensitivity_ctl_reg <= req.wdata;
      end
      if (hit(req, `GPIO_ADDR_SEL)) begin
        ext_irq_select_reg <= req.wdata;
      end
    end
  end

  // Pad drive: peripheral output first, then latch with push-pull or open-drain
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (alt_out_en[i]) begin
        drive_lvl[i] = alt_out_val[i];
        drive_en[i] = 1'b1;
      end else if (port_direction_reg[i]) begin
        drive_lvl[i] = port_data_latch_reg[i];
        drive_en[i] = port_option_reg[i] | ~port_data_latch_reg[i];
      end else begin
        drive_lvl[i] = 1'b0;
        drive_en[i] = 1'b0;
      end
    end
  end

  // Interrupt pins: input, option set, capable, selected by software and not driven by a peripheral output
  assign int_en = ~port_direction_reg & port_option_reg & IRQ_CAPABLE & ext_irq_select_reg
    & ~alt_out_en;

  // Registered pad and peripheral-side outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pad <= '0;
      alt_in <= 8'h00;
      adc_sw <= 8'h00;
    end else begin
      pad.out <= drive_lvl;
      pad.oe <= drive_en;
      pad.pull_en <= ~port_direction_reg & ~alt_out_en & port_option_reg;
      for (int i = 0; i < 8; i++) begin
        if (port_direction_reg[i] && alt_in_en[i]) begin
          alt_in[i] <= port_data_latch_reg[i];
        end else begin
          alt_in[i] <= sync2_reg[i];
        end
      end
      // Analog switch closes only on a floating input so no driver fights the ADC
      adc_sw <= adc_sel & ~port_direction_reg & ~port_option_reg & ~alt_out_en;
    end
  end

  // Read data, valid the cycle after the read strobe
  always_comb begin
    rd_next = 8'h00;
    case (req.addr)
      `GPIO_ADDR_DATA: begin
        for (int i = 0; i < 8; i++) begin
          if (alt_out_en[i] && !port_direction_reg[i]) begin
            rd_next[i] = alt_out_val[i];
          end else if (port_direction_reg[i]) begin
            rd_next[i] = port_data_latch_reg[i];
          end else begin
            rd_next[i] = sync2_reg[i];
          end
        end
      end
      `GPIO_ADDR_DIR: rd_next = port_direction_reg;
      `GPIO_ADDR_OPT: rd_next = port_option_reg;
      `GPIO_ADDR_SENS: rd_next = ext_irq_sensitivity_ctl_reg;
      `GPIO_ADDR_SEL: rd_next = ext_irq_select_reg;
      `GPIO_ADDR_PEND: rd_next = {4'h0, pending};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rd_next;
    end else begin
      rdata <= 8'h00;
    end
  end

  // One detector per vector on the AND of its enabled pins
  generate
    for (genvar v = 0; v < NV; v++) begin : g_vec
      logic grp_level;
      // Disabled pins read as high, so a low enabled pin masks the group
      assign grp_level = &(sync2_reg | ~(int_en & VEC_PINS[v]));
      assign sens_clear[v] = hit(req, `GPIO_ADDR_SENS)
        && (req.wdata[2*v+1 -: 2] != ext_irq_sensitivity_ctl_reg[2*v+1 -: 2]);
      gpio_edge_vec u_edge (
        .clock(clock),
        .arst_n(arst_n),
        .level(grp_level),
        .sens(ext_irq_sensitivity_ctl_reg[2*v] ? gpio_pkg::SENS_RISING : gpio_pkg::SENS_FALLING),
        .clear(vec_fetch[v] | sens_clear[v]),
        .pending(pending[v])
      );
    end
  endgenerate

  // Request reaches the core only while the global mask is clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 4'h0;
    end else begin
      irq_req <= pending & {NV{~irq_mask}};
    end
  end
endmodule

/* File: core/gpio_params.svh */
// Register offsets, reset values and vector count of the GPIO port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define GPIO_ADDR_DATA 8'h00
`define GPIO_ADDR_DIR 8'h01
`define GPIO_ADDR_OPT 8'h02
`define GPIO_ADDR_SENS 8'h03
`define GPIO_ADDR_SEL 8'h04
`define GPIO_ADDR_PEND 8'h05
`define GPIO_RST_DATA 8'hFF
`define GPIO_RST_DIR 8'h00
`define GPIO_RST_OPT 8'h00
`define GPIO_RST_SENS 8'h00
`define GPIO_RST_SEL 8'h00
`define GPIO_NUM_VEC 4
`endif

/* File: core/gpio_pkg.sv */
// Types shared by the GPIO port block
package gpio_pkg;
  // Register bus request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
  // Per-pin pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } pad_ctl_type;
  typedef enum logic {SENS_FALLING, SENS_RISING} sens_type;
endpackage

/* File: core/gpio_edge_vec.sv */
// Edge detector and pending latch for one external interrupt vector
`timescale 1ns/1ps
module gpio_edge_vec (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic level,
  input wire gpio_pkg::sens_type sens,
  input wire logic clear,
  output logic pending
);
  logic level_reg;

  // Previous level for edge compare
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= 1'b1;
    end else begin
      level_reg <= level;
    end
  end

  // Set wins over a same-cycle clear so no event is lost
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pending <= 1'b0;
    end else if ((sens == gpio_pkg::SENS_RISING) ? (level && !level_reg) : (!level && level_reg)) begin
      pending <= 1'b1;
    end else if (clear) begin
      pending <= 1'b0;
    end
  end
endmodule

/* File: bench/gpio_port_assertions.sv */
// Boundary assertions for the GPIO port
`timescale 1ns/1ps
module gpio_port_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire gpio_pkg::reg_req_type req,
  input wire logic [7:0] rdata,
  input wire gpio_pkg::pad_ctl_type pad,
  input wire logic [7:0] alt_out_en,
  input wire logic [7:0] alt_out_val,
  input wire logic irq_mask,
  input wire logic [3:0] vec_fetch,
  input wire logic [3:0] irq_req
);
  logic [7:0] lat_reg, dir_reg, opt_reg, sens_reg;
  logic [3:0] chg;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Shadow of the data, direction, option and sensitivity registers, so pad values can be predicted
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lat_reg <= 8'hFF;
      dir_reg <= 8'h00;
      opt_reg <= 8'h00;
      sens_reg <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == 8'h00) lat_reg <= req.wdata;
      if (req.addr == 8'h01) dir_reg <= req.wdata;
      if (req.addr == 8'h02) opt_reg <= req.wdata;
      if (req.addr == 8'h03) sens_reg <= req.wdata;
    end
  end
  // Vectors whose sensitivity pair the bus data would change
  for (genvar k = 0; k < 4; k++) begin : g_chg
    assign chg[k] = |(req.wdata[2*k+:2] ^ sens_reg[2*k+:2]);
  end
  sequence s_sens_wr;
    req.wr && req.addr == 8'h03;
  endsequence
  // Pads lag their cause by one registered stage
  AST_OE:
    assert property (pad.oe == $past(alt_out_en | (dir_reg & (opt_reg | ~lat_reg)))) else $error("oe");
  AST_OUT:
    assert property (((pad.out ^ $past(alt_out_en & alt_out_val | ~alt_out_en & lat_reg)) & pad.oe) == 8'h00)
      else $error("out");
  AST_PULL: assert property (pad.pull_en == $past(~dir_reg & opt_reg & ~alt_out_en)) else $error("pull");
  AST_PULL_OFF: assert property ((pad.pull_en & pad.oe) == 8'h00) else $error("pull on driven pin");
  AST_RD:
    assert property (req.rd && req.addr == 8'h00 |=>
      ((rdata ^ $past(lat_reg)) & $past(dir_reg & ~alt_out_en)) == 8'h00) else $error("rd");
  AST_MASK: assert property (irq_mask |=> irq_req == 4'h0) else $error("mask");
  AST_FETCH:
    assert property (vec_fetch != 4'h0 |-> ##2 (irq_req & $past(vec_fetch, 2)) == 4'h0) else $error("fetch");
  AST_SENS: assert property (s_sens_wr |-> ##2 (irq_req & $past(chg, 2)) == 4'h0) else $error("sens");
endmodule
bind gpio_port gpio_port_checker u_chk (.clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .pad(pad),
  .alt_out_en(alt_out_en), .alt_out_val(alt_out_val), .irq_mask(irq_mask), .vec_fetch(vec_fetch), .irq_req(irq_req));

/* File: bench/pin_env.sv */
// Pin model: pad drive against an always-present outside driver
`timescale 1ns/1ps
module pin_env (
  input wire gpio_pkg::pad_ctl_type pad,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // Driving pads win; released pads show the outside level
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_val);
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the GPIO port
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [7:0] d, o, l, oe, pu, rd;} row_type;
  row_type rows [3] = '{'{8'h00, 8'hFF, 8'h3C, 8'h00, 8'hFF, 8'hC3},
    '{8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'h00, 8'hA5}, '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'h00, 8'hA5}};
  logic clock, arst_n, mask;
  gpio_pkg::reg_req_type req;
  gpio_pkg::pad_ctl_type pad;
  logic [7:0] rdata, pin_in, ao_en, ao_val, ai_en, ext, alt_in, adc_sw;
  logic [3:0] fetch, irq;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  gpio_port dut (.clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .pin_in(pin_in), .pad(pad),
    .alt_out_en(ao_en), .alt_out_val(ao_val), .alt_in_en(ai_en), .alt_in(alt_in), .adc_sel(8'h01),
    .adc_sw(adc_sw), .irq_mask(mask), .vec_fetch(fetch), .irq_req(irq));
  pin_env env (.pad(pad), .ext_val(ext), .pin_in(pin_in));
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Bus cycles: one-cycle strobes, read data checked in the following cycle
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input string n);
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req.rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  // Pin change, then enough cycles for sync, pending and request stages
  task automatic ev(input logic [7:0] x);
    @(posedge clock) ext <= x;
    st(6);
  endtask
  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Hang guard, well above the 150 or so cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    arst_n = 1'b0;
    mask = 1'b0;
    fetch = 4'h0;
    ao_en = 8'h00;
    ao_val = 8'h00;
    ai_en = 8'hFF;
    req = '0;
    ext = 8'hC3;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 1; a < 8; a++) rd(8'(a), 8'h00, "reset");
    // Table of plain pin setups
    foreach (rows[i]) begin
      wr(8'h01, rows[i].d);
      wr(8'h02, rows[i].o);
      wr(8'h00, rows[i].l); // Whole-byte write, never a bit set or clear
      rd(8'h00, rows[i].rd, "data");
      chk("oe", pad.oe, rows[i].oe);
      chk("out", pad.out & pad.oe, rows[i].l & rows[i].oe);
      chk("pull", pad.pull_en, rows[i].pu);
    end
    // Pin 1 on vector 0, falling edge; fetch, mask, then resensitise
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h06);
    // Select still clear: the edge must not register
    ev(8'hC1);
    rd(8'h05, 8'h00, "unsel");
    ev(8'hC3);
    // Select last, once the pin is a quiet input, so no stray request
    wr(8'h04, 8'h02);
    ev(8'hC1);
    chk("irq", {4'h0, irq}, 8'h01);
    @(posedge clock) fetch <= 4'h1;
    @(posedge clock) fetch <= 4'h0;
    st(3);
    chk("fetch", {4'h0, irq}, 8'h00);
    @(posedge clock) mask <= 1'b1;
    ev(8'hC3);
    ev(8'hC1);
    chk("masked", {4'h0, irq}, 8'h00);
    rd(8'h05, 8'h01, "pend");
    wr(8'h03, 8'h01);
    rd(8'h05, 8'h00, "sens");
    ev(8'hC3);
    rd(8'h05, 8'h01, "rise");
    // Pin 2 held low joins vector 0 and masks the rising edge of pin 1
    @(posedge clock) fetch <= 4'h1;
    @(posedge clock) fetch <= 4'h0;
    wr(8'h04, 8'h06);
    ev(8'hC1);
    ev(8'hC3);
    rd(8'h05, 8'h00, "grp");
    // Peripheral owns pin 0 while it is an input; read before the synchroniser catches up
    @(posedge clock) ao_en <= 8'h01;
    rd(8'h00, 8'hC2, "alt_rd");
    @(posedge clock) ao_val <= 8'h01;
    rd(8'h00, 8'hC3, "alt_val");
    chk("alt_oe", pad.oe & 8'h01, 8'h01);
    chk("alt_drv", pad.out & 8'h01, 8'h01);
    @(posedge clock) ao_en <= 8'h00;
    wr(8'h02, 8'h00); // Interrupt option off before alternate input use
    st(4);
    chk("alt_in", alt_in, 8'hC3);
    chk("adc", adc_sw, 8'h01);
    wr(8'h00, 8'h0F);
    wr(8'h01, 8'hFF);
    st(3);
    chk("alt_out", alt_in, 8'h0F);
    chk("adc_off", adc_sw, 8'h00);
    // Alternate input not enabled: the peripheral sees the open-drain pin level
    @(posedge clock) ai_en <= 8'h00;
    st(2);
    chk("alt_pin", alt_in, 8'h03);
    // Mid-run reset: pads release at once, registers restart
    @(posedge clock) arst_n <= 1'b0;
    st(1);
    chk("rst_oe", pad.oe, 8'h00);
    chk("rst_alt", alt_in, 8'h00);
    @(posedge clock) arst_n <= 1'b1;
    rd(8'h01, 8'h00, "rst_dir");
    rd(8'h00, 8'hC3, "rst_data");
    wrap_up;
  end
endmodule
